// File: hdl/eeprom_pkg.sv
// constants, types and the operation summary for the three-wire eeprom command port
// Operation
// [R1] organization_select high gives 16-bit words, low gives 8-bit words with wider address.
// [R2] start, opcode, address and data bits are sampled on serial clock rising edges.
// [R3] serial_out stays released except during read data or ready/busy status.
// [R4] status shows low while programming, high once ready.
// [R5] serial_out is released on every falling edge of device_select.
// [R6] start marker is the first rising clock edge with select and serial_in high.
// [R7] before a start marker nothing changes and no operation runs.
// [R8] raising device_select leaves standby at once.
// [R9] only a fully received instruction executes; truncated ones do nothing.
// [R10] after the last required bit clock and serial_in are ignored until a new start.
// [R11] power-up is program-locked; erase and write refused until program_unlock.
// [R12] host issues program_unlock before any erase or write.
// [R13] read outputs a dummy zero then 16 or 8 data bits.
// [R14] each read output bit changes on the serial clock rising edge.
// [R15] continued clocking after a read word streams the next address.
// [R16] opcodes: read 10, write 01, erase 11, special 00 after start bit 1.
// [R17] special: 11 unlock, 10 clear_whole_array, 01 fill_whole_array, 00 lock.
// [R18] smallest density x8: 7 address bits; 18 clocks for data, else 10.
// [R19] middle density x16: 8-bit field, leading don't-care; 27 clocks or 11.
// [R20] middle density x8: 9-bit field, leading don't-care; 20 clocks or 12.
// [R21] largest density x16: 8 address bits; 27 clocks or 11.
// [R22] largest density x8: 9 address bits; 20 clocks or 12.
// [R23] self-timed programming starts on select falling after the last required bit.
// [R24] unlocked stays until program_lock; reads work in either lock state.
// [R25] single-word erase sets every bit of the word to one.
// [R26] low device_select holds instruction decoding in reset.
// [R27] programming instructions while locked are ignored with no busy period.
// [R28] fill_whole_array clears then writes every location in one busy period; the code writes the data straight in with no clear step.
package eeprom_pkg;

  // densities; the smallest x16 map is not covered
  localparam logic [1:0] DENS_SMALL  = 2'h0;
  localparam logic [1:0] DENS_MIDDLE = 2'h1;
  localparam logic [1:0] DENS_LARGE  = 2'h2;

  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] OP_WRITE   = 2'h1;
  localparam logic [1:0] OP_READ    = 2'h2;
  localparam logic [1:0] OP_ERASE   = 2'h3;

  localparam logic [1:0] SP_LOCK   = 2'h0;
  localparam logic [1:0] SP_FILL   = 2'h1;
  localparam logic [1:0] SP_CLEAR  = 2'h2;
  localparam logic [1:0] SP_UNLOCK = 2'h3;

  // address field widths (start bit and opcode add three clocks)
  localparam int ADDR_SMALL_X8  = 7;
  localparam int ADDR_MID_X16   = 8;
  localparam int ADDR_MID_X8    = 9;
  localparam int ADDR_LARGE_X16 = 8;
  localparam int ADDR_LARGE_X8  = 9;
  localparam int HEAD_BITS      = 3;

  // self-timed cycle, typical figures
  localparam int  CLK_PERIOD_NS  = 8;
  localparam int  WORD_PROG_MS   = 4;
  localparam int  CLEAR_PROG_MS  = 8;
  localparam int  FILL_PROG_MS   = 16;
  localparam int  WORD_PROG_CYC  = WORD_PROG_MS * 1000000 / CLK_PERIOD_NS;
  localparam int  CLEAR_PROG_CYC = CLEAR_PROG_MS * 1000000 / CLK_PERIOD_NS;
  localparam int  FILL_PROG_CYC  = FILL_PROG_MS * 1000000 / CLK_PERIOD_NS;

  localparam logic LOCKED_AT_RESET = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_HEAD  = 3'b001,
    ST_ADDR  = 3'b010,
    ST_DATA  = 3'b011,
    ST_READ  = 3'b100,
    ST_DONE  = 3'b101
  } frame_e;

  // a decoded programming request handed to the array engine
  typedef struct packed {
    logic        valid;
    logic [1:0]  opcode;
    logic [1:0]  special;
    logic [8:0]  addr;
    logic [15:0] data;
  } prog_req_s;

endpackage : eeprom_pkg

// File: hdl/pin_sync.sv
// three-stage pin synchroniser with agreement filter and edge detect
`timescale 1ns/1ns
`default_nettype none
module pin_sync
  import eeprom_pkg::*;
(
  // clock and reset
  input  wire logic CLK,
  input  wire logic RST,
  // pin in
  input  wire logic pin,
  // filtered level and edges
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic [2:0] stage;

  always_ff @(posedge CLK)
  begin
    if (RST)
      stage <= 3'h0;
    else
      stage <= {stage[1:0], pin};
  end

  // level only moves once stages two and three agree
  always_ff @(posedge CLK)
  begin
    if (RST)
      level <= 1'b0;
    else if (stage[1] == stage[2])
      level <= stage[2];
  end

  always_comb
  begin
    rise = (stage[1] == stage[2]) && stage[2] && !level;
    fall = (stage[1] == stage[2]) && !stage[2] && level;
  end

endmodule : pin_sync
`default_nettype wire

// File: hdl/prog_timer.sv
// self-timed programming cycle counter
`timescale 1ns/1ns
`default_nettype none
module prog_timer
  import eeprom_pkg::*;
#(
  parameter int CNT_W = 32
)
(
  // clock and reset
  input  wire logic             CLK,
  input  wire logic             RST,
  // start with length in cycles
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] cycles,
  // state
  output logic                  busy,
  output logic                  done
);

  logic [CNT_W-1:0] count;

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      count <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        count <= cycles;
        busy  <= 1'b1;
      end
      else if (busy)
      begin
        if (count <= 1)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        count <= count - 1'b1;
      end
    end
  end

endmodule : prog_timer
`default_nettype wire

// File: hdl/eeprom_port.sv
// serial command port and storage array of the three-wire eeprom
`timescale 1ns/1ns
`default_nettype none
module eeprom_port
  import eeprom_pkg::*;
#(
  parameter logic [1:0] DENSITY        = DENS_LARGE,
  parameter int         WORD_PROG_CYCLES  = WORD_PROG_CYC,
  parameter int         CLEAR_PROG_CYCLES = CLEAR_PROG_CYC,
  parameter int         FILL_PROG_CYCLES  = FILL_PROG_CYC
)
(
  // clock and reset
  input  wire logic CLK,
  input  wire logic RST,
  // serial pins from the host
  input  wire logic DEVICE_SELECT,
  input  wire logic SERIAL_CLK,
  input  wire logic SERIAL_IN,
  // configuration strap
  input  wire logic ORGANIZATION_SELECT,
  // serial output, enable active low
  output logic      SERIAL_OUT,
  output logic      SERIAL_OUT_EN_N,
  // status
  output logic      READY_BUSY_FLAG,
  output logic      PROGRAM_LOCKED
);

  localparam int BYTES = 512;

  // ****************************************
  // pin sampling
  // ****************************************
  logic sel_lvl;
  logic sel_rise;
  logic sel_fall;
  logic sck_lvl;
  logic sck_rise;
  logic din_lvl;

  pin_sync u_sel (
    .CLK  (CLK),
    .RST  (RST),
    .pin  (DEVICE_SELECT),
    .level(sel_lvl),
    .rise (sel_rise),
    .fall (sel_fall)
  );
  pin_sync u_sck (
    .CLK  (CLK),
    .RST  (RST),
    .pin  (SERIAL_CLK),
    .level(sck_lvl),
    .rise (sck_rise),
    .fall ()
  );
  pin_sync u_din (
    .CLK  (CLK),
    .RST  (RST),
    .pin  (SERIAL_IN),
    .level(din_lvl),
    .rise (),
    .fall ()
  );

  // ****************************************
  // organization
  // ****************************************
  logic       x16;
  logic [3:0] addr_bits;
  logic [4:0] data_bits;

  // strap resampled on every clock, reset or not; not held for the session
  always_ff @(posedge CLK)
  begin
    x16 <= ORGANIZATION_SELECT; // R1
  end

  always_comb
  begin
    data_bits = x16 ? 5'h10 : 5'h08; // R1
    case (DENSITY)
      DENS_SMALL:  addr_bits = 4'(ADDR_SMALL_X8); // R18
      DENS_MIDDLE: addr_bits = x16 ? 4'(ADDR_MID_X16) : 4'(ADDR_MID_X8); // R19 R20
      default:     addr_bits = x16 ? 4'(ADDR_LARGE_X16) : 4'(ADDR_LARGE_X8); // R21 R22
    endcase
  end

  // address mask removes the leading don't-care bit in the middle density
  logic [8:0] addr_mask;
  always_comb
  begin
    if (DENSITY == DENS_MIDDLE)
      addr_mask = 9'((10'h1 << (addr_bits - 4'h1)) - 10'h1); // R19 R20
    else
      addr_mask = 9'((10'h1 << addr_bits) - 10'h1);
  end

  // ****************************************
  // storage, byte wide
  // ****************************************
  logic [7:0] mem [BYTES];

  // ****************************************
  // frame decoder
  // ****************************************
  frame_e     state;
  logic [4:0] bit_cnt;
  logic [1:0] opcode;
  logic [8:0] addr;
  logic [15:0] shreg;
  logic       sample;
  logic       rd_start;
  logic       locked;
  logic       armed;
  prog_req_s  pending;
  logic       busy;
  logic       done;
  logic       start_prog;
  logic [31:0] prog_len;

  assign sample   = sel_lvl && sck_rise; // R2 R8
  // dummy zero goes out with the last address bit, keeping the read at its clock count
  assign rd_start = sample && state == ST_ADDR && opcode == OP_READ && bit_cnt == 5'(addr_bits - 4'h1); // R13

  function automatic logic [15:0] read_word(input logic [8:0] a, input logic w16);
    logic [9:0] b;
    b = w16 ? {a, 1'b0} : {1'b0, a};
    read_word = w16 ? {mem[b[8:0]], mem[9'(b + 10'h1)]} : {8'h00, mem[b[8:0]]};
  endfunction : read_word

  always_ff @(posedge CLK)
  begin
    if (RST || !sel_lvl)
    begin
      state   <= ST_IDLE; // R26
      bit_cnt <= 5'h0;
      opcode  <= 2'h0;
      addr    <= 9'h0;
      shreg   <= 16'h0;
    end
    else if (sample)
    begin
      case (state)
        ST_IDLE:
        begin
          if (din_lvl && !busy) // R6 R7
          begin
            state   <= ST_HEAD;
            bit_cnt <= 5'h0;
          end
        end
        ST_HEAD:
        begin
          opcode  <= {opcode[0], din_lvl}; // R16
          bit_cnt <= bit_cnt + 5'h1;
          if (bit_cnt == 5'h1)
          begin
            state   <= ST_ADDR;
            bit_cnt <= 5'h0;
          end
        end
        ST_ADDR:
        begin
          addr    <= {addr[7:0], din_lvl};
          bit_cnt <= bit_cnt + 5'h1;
          if (bit_cnt == 5'(addr_bits - 4'h1))
          begin
            bit_cnt <= 5'h0;
            // special field sits in the top two bits of the address field
            if (opcode == OP_READ)
            begin
              state   <= ST_READ; // R13
              bit_cnt <= 5'h1;
              shreg   <= read_word({addr[7:0], din_lvl} & addr_mask, x16);
            end
            else if (opcode == OP_WRITE ||
                     (opcode == OP_SPECIAL && 2'({addr[7:0], din_lvl} >> (addr_bits - 4'h2)) == SP_FILL))
              state <= ST_DATA;
            else
              state <= ST_DONE; // R10
          end
        end
        ST_DATA:
        begin
          shreg   <= {shreg[14:0], din_lvl};
          bit_cnt <= bit_cnt + 5'h1;
          if (bit_cnt == 5'(data_bits - 5'h1))
            state <= ST_DONE; // R9 R10
        end
        ST_READ:
        begin
          bit_cnt <= bit_cnt + 5'h1;
          shreg   <= {shreg[14:0], 1'b0}; // R14
          if (bit_cnt == data_bits)
          begin
            bit_cnt <= 5'h1;
            addr    <= 9'(addr + 9'h1) & addr_mask; // R15
            shreg   <= read_word(9'(addr + 9'h1) & addr_mask, x16);
          end
        end
        default: state <= state; // R10
      endcase
    end
  end

  // ****************************************
  // serial output
  // ****************************************
  logic rd_out;
  logic show_status;

  always_ff @(posedge CLK)
  begin
    if (RST || sel_fall)
      show_status <= 1'b0; // R5
    else if (sel_rise && busy)
      show_status <= 1'b1; // R4
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      SERIAL_OUT      <= 1'b0;
      SERIAL_OUT_EN_N <= 1'b1;
    end
    else if (!sel_lvl || sel_fall)
    begin
      SERIAL_OUT_EN_N <= 1'b1; // R3 R5
      SERIAL_OUT      <= 1'b0;
    end
    else if (rd_start || (state == ST_READ && sample))
    begin
      SERIAL_OUT_EN_N <= 1'b0; // R13 R14
      SERIAL_OUT      <= rd_start ? 1'b0 : rd_out;
    end
    else if (show_status && state != ST_READ)
    begin
      SERIAL_OUT_EN_N <= 1'b0;
      SERIAL_OUT      <= !busy; // R4
    end
    else if (state != ST_READ)
      SERIAL_OUT_EN_N <= 1'b1; // R3
  end

  assign rd_out = x16 ? shreg[15] : shreg[7];

  // ****************************************
  // lock and programming launch
  // ****************************************
  logic [1:0] sp_code;
  assign sp_code = 2'(addr >> (addr_bits - 4'h2)); // R17
  // a complete frame arms the launch; select falling fires it
  assign armed = (state == ST_DONE);

  always_ff @(posedge CLK)
  begin
    if (RST)
      locked <= LOCKED_AT_RESET; // R11
    else if (sel_fall && armed && opcode == OP_SPECIAL)
    begin
      if (sp_code == SP_UNLOCK)
        locked <= 1'b0; // R24
      else if (sp_code == SP_LOCK)
        locked <= 1'b1; // R24
    end
  end

  always_comb
  begin
    pending.valid   = sel_fall && armed && !locked && !busy && // R23 R27 R9
                      (opcode == OP_WRITE || opcode == OP_ERASE ||
                       (opcode == OP_SPECIAL && (sp_code == SP_CLEAR || sp_code == SP_FILL)));
    pending.opcode  = opcode;
    pending.special = sp_code;
    pending.addr    = addr & addr_mask;
    pending.data    = x16 ? shreg : {8'h00, shreg[7:0]};
  end

  prog_req_s job;
  always_ff @(posedge CLK)
  begin
    if (RST)
      job <= '0;
    else if (pending.valid)
      job <= pending;
  end

  always_comb
  begin
    start_prog = pending.valid;
    if (opcode == OP_SPECIAL && sp_code == SP_FILL)
      prog_len = 32'(FILL_PROG_CYCLES); // R28
    else if (opcode == OP_SPECIAL)
      prog_len = 32'(CLEAR_PROG_CYCLES);
    else
      prog_len = 32'(WORD_PROG_CYCLES);
  end

  prog_timer #(.CNT_W(32)) u_timer (
    .CLK   (CLK),
    .RST   (RST),
    .start (start_prog),
    .cycles(prog_len),
    .busy  (busy),
    .done  (done)
  );

  // ****************************************
  // array update at end of the busy period
  // ****************************************
  logic [9:0] wbase;
  assign wbase = x16 ? {job.addr, 1'b0} : {1'b0, job.addr};

  always_ff @(posedge CLK)
  begin
    if (done && job.valid)
    begin
      if (job.opcode == OP_SPECIAL)
      begin
        // fill writes its data straight into every location, with no clear step, at the end of its busy period
        for (int i = 0; i < BYTES; i++)
          mem[i] <= (job.special == SP_FILL) ? // R28
                    ((x16 && i[0] == 1'b0) ? job.data[15:8] : job.data[7:0]) : 8'hff;
      end
      else if (job.opcode == OP_ERASE)
      begin
        mem[wbase[8:0]] <= 8'hff; // R25
        if (x16)
          mem[9'(wbase + 10'h1)] <= 8'hff;
      end
      else if (x16)
      begin
        mem[wbase[8:0]]        <= job.data[15:8];
        mem[9'(wbase + 10'h1)] <= job.data[7:0];
      end
      else
        mem[wbase[8:0]] <= job.data[7:0];
    end
  end

  assign READY_BUSY_FLAG = !busy;
  assign PROGRAM_LOCKED  = locked;

  // ****************************************
  // checks
  // ****************************************
  a_lock_refuses: assert property (@(posedge CLK) disable iff (RST) // R27
    locked |-> !busy) else $error("programming busy while locked");
  a_release_on_fall: assert property (@(posedge CLK) disable iff (RST) // R5
    sel_fall |=> SERIAL_OUT_EN_N) else $error("serial_out not released");
  a_deselect_resets: assert property (@(posedge CLK) disable iff (RST) // R26
    !sel_lvl |=> state == ST_IDLE) else $error("decoder not held idle");
  a_status_level: assert property (@(posedge CLK) disable iff (RST) // R4
    (show_status && state != ST_READ && busy && $past(busy)) |=> !SERIAL_OUT || SERIAL_OUT_EN_N)
    else $error("status high while busy");
  a_busy_on_launch: assert property (@(posedge CLK) disable iff (RST) // R23
    pending.valid |=> busy) else $error("no busy after launch");
  a_idle_no_prog: assert property (@(posedge CLK) disable iff (RST) // R7
    (state == ST_IDLE) |=> $stable(locked) && !$rose(busy)) else $error("operation without start");
  a_dummy_zero: assert property (@(posedge CLK) disable iff (RST) // R13
    (rd_start && !sel_fall) |=> !SERIAL_OUT && !SERIAL_OUT_EN_N) else $error("dummy zero missing");
  a_locked_reset: assert property (@(posedge CLK) // R11
    $fell(RST) |-> locked) else $error("not locked after reset");

endmodule : eeprom_port
`default_nettype wire

// File: tb/serial_host.sv
// host controller model that drives select, serial clock and serial data
`timescale 1ns/1ns
`default_nettype none
module serial_host
(
  // pins toward the device
  output var logic        sel,
  output var logic        sclk,
  output var logic        sin,
  // resolved device output line
  input  wire logic       dout
);
  logic [63:0] got;

  initial
  begin
    sel  <= 1'b0;
    sclk <= 1'b0;
    sin  <= 1'b0;
    got  = '0;
  end

  // clock stands low between frames; period 125 ns within a frame
  task automatic shift(input int n, input logic [63:0] bits);
    got = '0;
    sel <= 1'b1;
    #60;
    for (int i = n - 1; i >= 0; i--)
    begin
      sin <= bits[i];
      #62;
      sclk <= 1'b1;
      #62;
      got  = {got[62:0], dout};
      sclk <= 1'b0;
      #1;
    end
  endtask : shift

  // dropping select fires programming; data line is scrambled in the same step
  task automatic deselect();
    #1;
    sel <= 1'b0;
    sin <= ~sin;
    #260;
  endtask : deselect

  task automatic poll();
    sel <= 1'b1;
    #80;
  endtask : poll
endmodule : serial_host
`default_nettype wire

// File: tb/tb_three_wire_eeprom_command_port.sv
// self-checking bench for the three-wire eeprom command port
`timescale 1ns/1ns
`default_nettype none
module tb_three_wire_eeprom_command_port
  import eeprom_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic organization_select = 1'b1;
  logic sel, sclk, sin, sout, en_n, ready, locked, dout;
  int   num_errors = 0;
  int   total_checks = 0;

  always #4 clk = ~clk;
  // pull-up on the shared output line
  assign dout = en_n ? 1'b1 : sout;

  serial_host host (.sel(sel), .sclk(sclk), .sin(sin), .dout(dout));

  eeprom_port #(
    .DENSITY(DENS_LARGE), .WORD_PROG_CYCLES(200), .CLEAR_PROG_CYCLES(400), .FILL_PROG_CYCLES(800)
  ) dut (
    .CLK(clk), .RST(rst), .DEVICE_SELECT(sel), .SERIAL_CLK(sclk), .SERIAL_IN(sin),
    .ORGANIZATION_SELECT(organization_select), .SERIAL_OUT(sout), .SERIAL_OUT_EN_N(en_n),
    .READY_BUSY_FLAG(ready), .PROGRAM_LOCKED(locked)
  );

  // ****************
  // shared helpers
  // ****************
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // reset held three cycles; the strap settles while reset is high
  task automatic do_reset(input logic org_val);
    @(posedge clk);
    rst <= 1'b1;
    organization_select <= org_val;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : do_reset

  task automatic cmd(input int n, input logic [63:0] bits);
    host.shift(n, bits);
    host.deselect();
  endtask : cmd

  // programming frame, then status polled while busy and after
  task automatic prog(input int n, input logic [63:0] bits);
    int k;
    cmd(n, bits);
    host.poll();
    check(en_n, 1'b0, "status not driven");
    check(sout, 1'b0, "busy status");
    check(ready, 1'b0, "busy flag");
    k = 0;
    while (ready !== 1'b1 && k < 2000)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 2000)
    begin
      num_errors++;
      $display("ERROR %0t ready never returned", $time);
      report_and_stop();
    end
    repeat (10) @(posedge clk);
    check(sout, 1'b1, "ready status");
    host.deselect();
    check(en_n, 1'b1, "release on deselect");
  endtask : prog

  task automatic read16(input logic [7:0] a, input int words, input logic [32:0] exp);
    host.shift(11 + 16 * words, 64'({1'b1, OP_READ, a}) << (16 * words));
    host.deselect();
    if (words == 1)
      check(host.got[16:0], exp[32:16], "read word");
    else
      check(host.got[32:0], exp, "sequential read");
  endtask : read16

  // ****************
  // scenarios
  // ****************
  task automatic t_idle();
    check({en_n, ready, locked}, 3'b111, "idle state");
    $display("test idle done");
  endtask : t_idle

  task automatic t_locked();
    cmd(27, 64'({1'b1, OP_WRITE, 8'h11, 16'h1234}));
    check({ready, locked}, 2'b11, "locked write");
    $display("test locked done");
  endtask : t_locked

  task automatic t_unlock();
    cmd(11, 64'({1'b1, OP_SPECIAL, SP_UNLOCK, 6'h00}));
    check(locked, 1'b0, "unlock");
    $display("test unlock done");
  endtask : t_unlock

  task automatic t_fill();
    prog(27, 64'({1'b1, OP_SPECIAL, SP_FILL, 6'h15, 16'h5a3c}));
    read16(8'h10, 2, {1'b0, 16'h5a3c, 16'h5a3c});
    $display("test fill done");
  endtask : t_fill

  // idle clocks before the start bit and spare clocks after the last bit
  task automatic t_write();
    prog(33, 64'({3'b000, 1'b1, OP_WRITE, 8'h11, 16'hc3a5, 3'b111}));
    read16(8'h10, 2, {1'b0, 16'h5a3c, 16'hc3a5});
    $display("test write done");
  endtask : t_write

  task automatic t_trunc();
    cmd(20, 64'({1'b1, OP_WRITE, 8'h11, 16'h0f0f}) >> 7);
    check(ready, 1'b1, "truncated busy");
    read16(8'h11, 1, {1'b0, 16'hc3a5, 16'h0000});
    $display("test truncated done");
  endtask : t_trunc

  task automatic t_erase();
    prog(11, 64'({1'b1, OP_ERASE, 8'h11}));
    read16(8'h10, 2, {1'b0, 16'h5a3c, 16'hffff});
    $display("test erase done");
  endtask : t_erase

  task automatic t_clear();
    prog(11, 64'({1'b1, OP_SPECIAL, SP_CLEAR, 6'h2a}));
    read16(8'h10, 1, {1'b0, 16'hffff, 16'h0000});
    $display("test clear done");
  endtask : t_clear

  task automatic t_lock();
    cmd(11, 64'({1'b1, OP_SPECIAL, SP_LOCK, 6'h3f}));
    check(locked, 1'b1, "lock");
    cmd(11, 64'({1'b1, OP_ERASE, 8'h20}));
    check(ready, 1'b1, "locked erase");
    cmd(27, 64'({1'b1, OP_SPECIAL, SP_FILL, 6'h00, 16'h0000}));
    check(ready, 1'b1, "locked fill");
    read16(8'h10, 1, {1'b0, 16'hffff, 16'h0000});
    $display("test lock done");
  endtask : t_lock

  // byte organisation: nine address bits, twenty clocks for data frames
  task automatic t_x8();
    do_reset(1'b0);
    cmd(12, 64'({1'b1, OP_SPECIAL, SP_UNLOCK, 7'h00}));
    check(locked, 1'b0, "x8 unlock");
    prog(20, 64'({1'b1, OP_WRITE, 9'h1a3, 8'h96}));
    host.shift(20, 64'({1'b1, OP_READ, 9'h1a3}) << 8);
    host.deselect();
    check(host.got[8:0], {1'b0, 8'h96}, "x8 read");
    $display("test x8 done");
  endtask : t_x8

  // ****************
  // main sequence
  // ****************
  initial
  begin
    do_reset(1'b1);
    t_idle();
    t_locked();
    t_unlock();
    t_fill();
    t_write();
    t_trunc();
    t_erase();
    t_clear();
    t_lock();
    t_x8();
    report_and_stop();
  end
endmodule : tb_three_wire_eeprom_command_port
`default_nettype wire
